// [src/lm_defs.svh]
`ifndef LM_DEFS_SVH
`define LM_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define LM_OFS_UNIT      8'h00
`define LM_OFS_MODE      8'h04
`define LM_OFS_POWER     8'h08
`define LM_OFS_OPSTATE   8'h0C
`define LM_OFS_SYSSTAT   8'h10
`define LM_OFS_IRQ_STAT  8'h14
`define LM_OFS_IRQ_MASK  8'h18
`define LM_OFS_LINK      8'h1C

// ****************************************
// Command codes
// ****************************************
`define LM_CMD_OPSTATE   8'h84
`define LM_CMD_MODE      8'h14
`define LM_CMD_POWER     8'h4E

// ****************************************
// Field positions
// ****************************************
`define LM_MODE_DIG_EN   0
`define LM_MODE_DIG_INV  1
`define LM_MODE_EXT_EN   2
`define LM_MODE_ANA_EN   3
`define LM_AVAIL_BIT     8
`define LM_IRQ_DONE      0
`define LM_IRQ_CKSUM     1
`define LM_IRQ_BADCMD    2
`define LM_REQ_LAST      2'h3

// ****************************************
// Reset values and fixed bytes
// ****************************************
`define LM_RST_UNIT      7'h10
`define LM_RST_MODE      4'h0
`define LM_RST_POWER     8'h00
`define LM_RST_SYSSTAT   8'h00
`define LM_RST_MASK      3'h0
`define LM_FILL_COUNT    2
`define LM_FILL_BYTE     8'h00
`define LM_RESP_OKAY     2'h0
`define LM_RESP_SLVERR   2'h2

`endif

// [src/lm_pkg.sv]
package lm_pkg;

   typedef enum logic [5:0]
   {
      st_rx   = 6'h01,
      st_addr = 6'h02,
      st_stat = 6'h04,
      st_data = 6'h08,
      st_sum  = 6'h10,
      st_fill = 6'h20
   } lm_fsm_e;

   typedef enum logic [2:0]
   {
      state_startup   = 3'h0,
      state_standby   = 3'h1,
      state_ready     = 3'h2,
      state_service   = 3'h3,
      state_failure   = 3'h4,
      state_powerdown = 3'h5
   } lm_opstate_e;

endpackage

// [src/lm_cksum.sv]
`timescale 1ns/1ns
`default_nettype none

module lm_cksum
(
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   input  wire logic       i_load,
   input  wire logic       i_add,
   input  wire logic [7:0] i_byte,
   output logic      [7:0] o_sum
);

   logic [7:0] sum_q;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         sum_q <= 8'h00;
      else if (i_load)
         sum_q <= i_byte;
      else if (i_add)
         sum_q <= sum_q ^ i_byte;
   end

   assign o_sum = sum_q;

endmodule

`default_nettype wire

// [src/lm_axil_slave.sv]
`timescale 1ns/1ns
`default_nettype none
`include "lm_defs.svh"

module lm_axil_slave
(
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic      [1:0]  o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic      [31:0] o_rdata,
   output logic      [1:0]  o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   output logic             o_wr_en,
   output logic      [7:0]  o_wr_addr,
   output logic      [31:0] o_wr_data,
   output logic      [3:0]  o_wr_strb,
   input  wire logic        i_wr_err,
   output logic             o_rd_en,
   output logic      [7:0]  o_rd_addr,
   input  wire logic [31:0] i_rd_data,
   input  wire logic        i_rd_err
);

   logic        aw_rdy_q;
   logic        w_rdy_q;
   logic        ar_rdy_q;
   logic        b_vld_q;
   logic        r_vld_q;
   logic [7:0]  aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;
   logic [1:0]  b_resp_q;
   logic [1:0]  r_resp_q;
   logic [31:0] r_data_q;

   wire aw_fire = i_awvalid & aw_rdy_q;
   wire w_fire  = i_wvalid & w_rdy_q;
   // Both halves held and no response pending
   wire wr_go   = ~aw_rdy_q & ~w_rdy_q & ~b_vld_q;
   wire rd_go   = i_arvalid & ar_rdy_q;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         aw_rdy_q  <= 1'h1;
         w_rdy_q   <= 1'h1;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         b_vld_q   <= 1'h0;
         b_resp_q  <= `LM_RESP_OKAY;
      end
      else
      begin
         if (aw_fire)
         begin
            aw_rdy_q  <= 1'h0;
            aw_addr_q <= i_awaddr;
         end
         else if (wr_go)
            aw_rdy_q <= 1'h1;
         if (w_fire)
         begin
            w_rdy_q  <= 1'h0;
            w_data_q <= i_wdata;
            w_strb_q <= i_wstrb;
         end
         else if (wr_go)
            w_rdy_q <= 1'h1;
         if (wr_go)
         begin
            b_vld_q  <= 1'h1;
            b_resp_q <= i_wr_err ? `LM_RESP_SLVERR : `LM_RESP_OKAY;
         end
         else if (i_bready)
            b_vld_q <= 1'h0;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ar_rdy_q <= 1'h1;
         r_vld_q  <= 1'h0;
         r_data_q <= 32'h0000_0000;
         r_resp_q <= `LM_RESP_OKAY;
      end
      else if (rd_go)
      begin
         ar_rdy_q <= 1'h0;
         r_vld_q  <= 1'h1;
         r_data_q <= i_rd_data;
         r_resp_q <= i_rd_err ? `LM_RESP_SLVERR : `LM_RESP_OKAY;
      end
      else if (r_vld_q & i_rready)
      begin
         r_vld_q  <= 1'h0;
         ar_rdy_q <= 1'h1;
      end
   end

   assign o_awready = aw_rdy_q;
   assign o_wready  = w_rdy_q;
   assign o_bvalid  = b_vld_q;
   assign o_bresp   = b_resp_q;
   assign o_arready = ar_rdy_q;
   assign o_rvalid  = r_vld_q;
   assign o_rdata   = r_data_q;
   assign o_rresp   = r_resp_q;
   assign o_wr_en   = wr_go;
   assign o_wr_addr = aw_addr_q;
   assign o_wr_data = w_data_q;
   assign o_wr_strb = w_strb_q;
   assign o_rd_en   = rd_go;
   assign o_rd_addr = i_araddr;

endmodule

`default_nettype wire

// [src/lm_mode_reader.sv]
// Contract
// - Operating state byte uses six codes
// - Unavailable data: status, checksum, then fill
// - Code 0x14 returns address, status, mode, checksum
// - Mode bit 0 digital modulation enable
// - Mode bit 1 digital modulation inversion
// - Mode bit 2 external enable, locked if safety
// - Mode bit 3 analog modulation enable
// - Code 0x4E returns power percentage byte
// - Power reply is programmed, not measured
`timescale 1ns/1ns
`default_nettype none
`include "lm_defs.svh"

module lm_mode_reader
#(
   parameter bit         SAFETY_CFG   = 1'b0,
   parameter bit         EXT_EN_FIXED = 1'b1,
   parameter int         FILL_COUNT   = `LM_FILL_COUNT,
   parameter logic [7:0] FILL_BYTE    = `LM_FILL_BYTE
)
(
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic [7:0]  i_awaddr,
   input  wire logic        i_awvalid,
   output logic             o_awready,
   input  wire logic [31:0] i_wdata,
   input  wire logic [3:0]  i_wstrb,
   input  wire logic        i_wvalid,
   output logic             o_wready,
   output logic      [1:0]  o_bresp,
   output logic             o_bvalid,
   input  wire logic        i_bready,
   input  wire logic [7:0]  i_araddr,
   input  wire logic        i_arvalid,
   output logic             o_arready,
   output logic      [31:0] o_rdata,
   output logic      [1:0]  o_rresp,
   output logic             o_rvalid,
   input  wire logic        i_rready,
   input  wire logic        i_rx_valid,
   input  wire logic [7:0]  i_rx_byte,
   output logic             o_rx_ready,
   output logic             o_tx_valid,
   output logic      [7:0]  o_tx_byte,
   input  wire logic        i_tx_ready,
   output logic             o_irq
);

   localparam logic [3:0] MODE_RST  = `LM_RST_MODE | {1'h0, EXT_EN_FIXED, 2'h0};
   localparam logic [3:0] FILL_LAST = 4'(FILL_COUNT - 1);

   // ****************************************
   // Register bus
   // ****************************************
   logic        wr_en;
   logic [7:0]  wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic        rd_en;
   logic [7:0]  rd_addr;
   logic [31:0] rd_data;
   logic        rd_err;
   logic        wr_err;

   lm_axil_slave u_bus
   (
      .i_clk     (i_clk),
      .i_rst     (i_rst),
      .i_awaddr  (i_awaddr),
      .i_awvalid (i_awvalid),
      .o_awready (o_awready),
      .i_wdata   (i_wdata),
      .i_wstrb   (i_wstrb),
      .i_wvalid  (i_wvalid),
      .o_wready  (o_wready),
      .o_bresp   (o_bresp),
      .o_bvalid  (o_bvalid),
      .i_bready  (i_bready),
      .i_araddr  (i_araddr),
      .i_arvalid (i_arvalid),
      .o_arready (o_arready),
      .o_rdata   (o_rdata),
      .o_rresp   (o_rresp),
      .o_rvalid  (o_rvalid),
      .i_rready  (i_rready),
      .o_wr_en   (wr_en),
      .o_wr_addr (wr_addr),
      .o_wr_data (wr_data),
      .o_wr_strb (wr_strb),
      .i_wr_err  (wr_err),
      .o_rd_en   (rd_en),
      .o_rd_addr (rd_addr),
      .i_rd_data (rd_data),
      .i_rd_err  (rd_err)
   );

   logic [6:0]          unit_addr_q;
   logic                avail_q;
   logic [3:0]          mode_q;
   logic [7:0]          power_q;
   lm_pkg::lm_opstate_e opstate_q;
   logic [7:0]          sysstat_q;
   logic [2:0]          irq_stat_q;
   logic [2:0]          irq_stat_d;
   logic [2:0]          irq_mask_q;
   logic                irq_q;
   logic [7:0]          cmd_q;
   lm_pkg::lm_fsm_e     state_q;
   lm_pkg::lm_fsm_e     state_d;

   wire sel_unit = wr_addr == `LM_OFS_UNIT;
   wire wr_unit  = wr_en & sel_unit;
   wire wr_mode  = wr_en & (wr_addr == `LM_OFS_MODE) & wr_strb[0];
   wire wr_power = wr_en & (wr_addr == `LM_OFS_POWER) & wr_strb[0];
   wire wr_opst  = wr_en & (wr_addr == `LM_OFS_OPSTATE) & wr_strb[0];
   wire wr_sys   = wr_en & (wr_addr == `LM_OFS_SYSSTAT) & wr_strb[0];
   wire wr_mask  = wr_en & (wr_addr == `LM_OFS_IRQ_MASK) & wr_strb[0];
   wire wr_hit   = sel_unit | (wr_addr == `LM_OFS_MODE) | (wr_addr == `LM_OFS_POWER)
                 | (wr_addr == `LM_OFS_OPSTATE) | (wr_addr == `LM_OFS_SYSSTAT)
                 | (wr_addr == `LM_OFS_IRQ_STAT) | (wr_addr == `LM_OFS_IRQ_MASK)
                 | (wr_addr == `LM_OFS_LINK);
   assign wr_err = ~wr_hit;

   // Safety units keep the external enable bit as strapped
   wire [3:0] mode_wr = SAFETY_CFG ? {wr_data[3], mode_q[`LM_MODE_EXT_EN], wr_data[1:0]}
                                   : wr_data[3:0];
   // Codes above the last defined state are dropped
   wire opst_ok = wr_data[2:0] <= lm_pkg::state_powerdown;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         unit_addr_q <= `LM_RST_UNIT;
         avail_q     <= 1'h1;
         mode_q      <= MODE_RST;
         power_q     <= `LM_RST_POWER;
         opstate_q   <= lm_pkg::state_startup;
         sysstat_q   <= `LM_RST_SYSSTAT;
         irq_mask_q  <= `LM_RST_MASK;
      end
      else
      begin
         if (wr_unit & wr_strb[0])
            unit_addr_q <= wr_data[6:0];
         if (wr_unit & wr_strb[1])
            avail_q <= wr_data[`LM_AVAIL_BIT];
         if (wr_mode)
            mode_q <= mode_wr;
         if (wr_power)
            power_q <= wr_data[7:0];
         if (wr_opst & opst_ok)
            opstate_q <= lm_pkg::lm_opstate_e'(wr_data[2:0]);
         if (wr_sys)
            sysstat_q <= wr_data[7:0];
         if (wr_mask)
            irq_mask_q <= wr_data[2:0];
      end
   end

   wire busy = state_q != lm_pkg::st_rx;
   wire rd_hit = (rd_addr == `LM_OFS_UNIT) | (rd_addr == `LM_OFS_MODE) | (rd_addr == `LM_OFS_POWER)
               | (rd_addr == `LM_OFS_OPSTATE) | (rd_addr == `LM_OFS_SYSSTAT)
               | (rd_addr == `LM_OFS_IRQ_STAT) | (rd_addr == `LM_OFS_IRQ_MASK)
               | (rd_addr == `LM_OFS_LINK);
   assign rd_err  = ~rd_hit;
   assign rd_data = (rd_addr == `LM_OFS_UNIT)     ? {23'h0, avail_q, 1'h0, unit_addr_q}
                  : (rd_addr == `LM_OFS_MODE)     ? {28'h0, mode_q}
                  : (rd_addr == `LM_OFS_POWER)    ? {24'h0, power_q}
                  : (rd_addr == `LM_OFS_OPSTATE)  ? {29'h0, opstate_q}
                  : (rd_addr == `LM_OFS_SYSSTAT)  ? {24'h0, sysstat_q}
                  : (rd_addr == `LM_OFS_IRQ_STAT) ? {29'h0, irq_stat_q}
                  : (rd_addr == `LM_OFS_IRQ_MASK) ? {29'h0, irq_mask_q}
                  : (rd_addr == `LM_OFS_LINK)     ? {23'h0, busy, cmd_q}
                  : 32'h0000_0000;

   // ****************************************
   // Request telegram intake
   // ****************************************
   logic       rx_ready_q;
   logic [1:0] idx_q;
   logic       addr_ok_q;
   logic [7:0] rx_sum;

   wire rx_fire   = i_rx_valid & rx_ready_q;
   wire last_byte = rx_fire & (idx_q == `LM_REQ_LAST);

   lm_cksum u_rx_sum
   (
      .i_clk  (i_clk),
      .i_rst  (i_rst),
      .i_load (rx_fire & (idx_q == 2'h0)),
      .i_add  (rx_fire & (idx_q != 2'h0) & (idx_q != `LM_REQ_LAST)),
      .i_byte (i_rx_byte),
      .o_sum  (rx_sum)
   );

   wire sum_ok    = i_rx_byte == rx_sum;
   wire cmd_known = (cmd_q == `LM_CMD_OPSTATE) | (cmd_q == `LM_CMD_MODE) | (cmd_q == `LM_CMD_POWER);
   wire good_req  = last_byte & addr_ok_q & sum_ok & cmd_known;
   wire ev_cksum  = last_byte & addr_ok_q & ~sum_ok;
   wire ev_badcmd = last_byte & addr_ok_q & sum_ok & ~cmd_known;

   // Sub address carries no meaning here and is not checked
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         idx_q     <= 2'h0;
         addr_ok_q <= 1'h0;
         cmd_q     <= 8'h00;
      end
      else if (rx_fire)
      begin
         idx_q <= idx_q + 2'h1;
         if (idx_q == 2'h0)
            addr_ok_q <= i_rx_byte == {unit_addr_q, 1'h0};
         if (idx_q == 2'h1)
            cmd_q <= i_rx_byte;
      end
   end

   // ****************************************
   // Reply sequencer
   // ****************************************
   logic       tx_valid_q;
   logic [7:0] tx_byte_q;
   logic [7:0] snap_raddr_q;
   logic [7:0] snap_stat_q;
   logic [7:0] snap_data_q;
   logic       snap_avail_q;
   logic [3:0] fill_q;
   logic [7:0] tx_byte_d;

   wire       tx_fire   = tx_valid_q & i_tx_ready;
   wire [7:0] raddr_w   = {unit_addr_q, 1'h1};
   wire [7:0] req_data  = (cmd_q == `LM_CMD_MODE)  ? {4'h0, mode_q}
                        : (cmd_q == `LM_CMD_POWER) ? power_q
                        : {5'h0, opstate_q};
   wire [7:0] tx_sum_w  = snap_raddr_q ^ snap_stat_q ^ (snap_avail_q ? snap_data_q : 8'h00);
   wire       fill_end  = fill_q == FILL_LAST;
   wire       ev_done   = tx_fire & (((state_q == lm_pkg::st_sum) & snap_avail_q)
                                   | ((state_q == lm_pkg::st_fill) & fill_end));

   always_comb
   begin
      state_d = state_q;
      case (state_q)
         lm_pkg::st_rx:   if (good_req) state_d = lm_pkg::st_addr;
         lm_pkg::st_addr: if (tx_fire) state_d = lm_pkg::st_stat;
         lm_pkg::st_stat: if (tx_fire) state_d = snap_avail_q ? lm_pkg::st_data : lm_pkg::st_sum;
         lm_pkg::st_data: if (tx_fire) state_d = lm_pkg::st_sum;
         lm_pkg::st_sum:  if (tx_fire) state_d = snap_avail_q ? lm_pkg::st_rx : lm_pkg::st_fill;
         lm_pkg::st_fill: if (tx_fire & fill_end) state_d = lm_pkg::st_rx;
         default:         state_d = lm_pkg::st_rx;
      endcase
   end

   assign tx_byte_d = (state_d == lm_pkg::st_addr) ? raddr_w
                    : (state_d == lm_pkg::st_stat) ? snap_stat_q
                    : (state_d == lm_pkg::st_data) ? snap_data_q
                    : (state_d == lm_pkg::st_sum)  ? tx_sum_w
                    : FILL_BYTE;

   // Byte is loaded on a state change or a fill byte handshake, so it holds while stalled
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_q      <= lm_pkg::st_rx;
         rx_ready_q   <= 1'h1;
         tx_valid_q   <= 1'h0;
         tx_byte_q    <= 8'h00;
         fill_q       <= 4'h0;
      end
      else
      begin
         state_q    <= state_d;
         rx_ready_q <= state_d == lm_pkg::st_rx;
         tx_valid_q <= state_d != lm_pkg::st_rx;
         if ((state_d != state_q) | (tx_fire & (state_q == lm_pkg::st_fill)))
            tx_byte_q <= tx_byte_d;
         fill_q <= (state_q != lm_pkg::st_fill) ? 4'h0 : fill_q + {3'h0, tx_fire};
      end
   end

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         snap_raddr_q <= 8'h00;
         snap_stat_q  <= 8'h00;
         snap_data_q  <= 8'h00;
         snap_avail_q <= 1'h0;
      end
      else if (good_req)
      begin
         snap_raddr_q <= raddr_w;
         snap_stat_q  <= sysstat_q;
         snap_data_q  <= req_data;
         snap_avail_q <= avail_q;
      end
   end

   // ****************************************
   // Interrupt
   // ****************************************
   // Read clears, but an event in the same cycle still lands
   wire       rd_clr = rd_en & (rd_addr == `LM_OFS_IRQ_STAT);
   wire [2:0] ev_vec = {ev_badcmd, ev_cksum, ev_done};
   assign irq_stat_d = (irq_stat_q & ~{3{rd_clr}}) | ev_vec;

   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         irq_stat_q <= 3'h0;
         irq_q      <= 1'h0;
      end
      else
      begin
         irq_stat_q <= irq_stat_d;
         irq_q      <= |(irq_stat_d & irq_mask_q);
      end
   end

   assign o_rx_ready = rx_ready_q;
   assign o_tx_valid = tx_valid_q;
   assign o_tx_byte  = tx_byte_q;
   assign o_irq      = irq_q;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   sequence seq_tx_fire;
      tx_valid_q && i_tx_ready;
   endsequence

   sequence seq_mode_req;
      good_req && cmd_q == `LM_CMD_MODE;
   endsequence

   chk_reply_addr_first: assert property (good_req |=> o_tx_valid && o_tx_byte == snap_raddr_q)
      else $error("reply does not open with read address");
   chk_opstate_range: assert property (opstate_q <= lm_pkg::state_powerdown)
      else $error("operating state code out of range");
   chk_no_data_fill: assert property ((state_q == lm_pkg::st_stat) && !snap_avail_q ##0 seq_tx_fire
                                      |=> state_q == lm_pkg::st_sum ##0 o_tx_byte == (snap_raddr_q ^ snap_stat_q))
      else $error("unavailable data not skipped to checksum");
   chk_fill_follows: assert property ((state_q == lm_pkg::st_sum) && !snap_avail_q ##0 seq_tx_fire
                                      |=> state_q == lm_pkg::st_fill && o_tx_byte == FILL_BYTE)
      else $error("fill byte missing after checksum");
   chk_mode_byte: assert property (seq_mode_req |=> snap_data_q == {4'h0, $past(mode_q)})
      else $error("mode byte does not match mode bits");
   chk_safety_lock: assert property (SAFETY_CFG && wr_mode |=> mode_q[2] == $past(mode_q[2]))
      else $error("external enable changed in safety unit");
   chk_power_prog: assert property (good_req && cmd_q == `LM_CMD_POWER |=> snap_data_q == $past(power_q))
      else $error("power reply not the programmed setting");
   chk_tx_hold: assert property (o_tx_valid && !i_tx_ready |=> o_tx_valid && $stable(o_tx_byte))
      else $error("reply byte changed while stalled");
   chk_data_then_sum: assert property ((state_q == lm_pkg::st_data) ##0 seq_tx_fire
                                       |=> o_tx_valid && o_tx_byte == (snap_raddr_q ^ snap_stat_q ^ snap_data_q))
      else $error("checksum does not follow data byte");

endmodule

`default_nettype wire

// [tb/lm_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module lm_host_model
(
   input  wire logic       i_clk,
   input  wire logic       i_rx_ready,
   output logic            o_rx_valid,
   output logic      [7:0] o_rx_byte,
   input  wire logic       i_tx_valid,
   input  wire logic [7:0] i_tx_byte,
   output logic            o_tx_ready
);
   logic [7:0] got [$];
   logic       slow = 1'b0;
   initial
   begin
      o_rx_valid = 1'b0;
      o_rx_byte  = 8'hFF;
      o_tx_ready = 1'b1;
   end
   // Slow host stalls every other cycle
   always @(posedge i_clk)
   begin
      if (i_tx_valid && o_tx_ready)
         got.push_back(i_tx_byte);
      o_tx_ready <= slow ? !o_tx_ready : 1'b1;
   end
   task automatic send(input logic [7:0] cmd, input logic [7:0] sub, input logic [7:0] flip);
      logic [7:0] t [4];
      t = '{8'h20, cmd, sub, 8'h20 ^ cmd ^ sub ^ flip};
      for (int i = 0; i < 4; i++)
      begin
         o_rx_valid <= 1'b1;
         o_rx_byte  <= t[i];
         do @(posedge i_clk); while (!i_rx_ready);
      end
      o_rx_valid <= 1'b0;
      // Released line must not keep the last byte
      o_rx_byte  <= ~t[3];
   endtask
endmodule
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ns
`default_nettype none
`include "lm_defs.svh"
module testbench;
   logic i_clk = 1'b0, i_rst = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, tx_byte, rx_byte;
   logic [31:0] wdata = 32'h0, rdata, d;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid, irq, rx_valid, rx_ready, tx_valid, tx_ready;
   logic [1:0] bresp, rresp, r;
   int fails = 0, comparisons = 0;
   always #50 i_clk = ~i_clk;
   // Safety build so the locked external enable bit is exercised
   lm_mode_reader #(.SAFETY_CFG(1'b1)) u_lm_mode_reader (.i_clk(i_clk), .i_rst(i_rst), .i_awaddr(awaddr),
      .i_awvalid(awvalid),
      .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready),
      .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
      .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
      .i_rx_valid(rx_valid), .i_rx_byte(rx_byte), .o_rx_ready(rx_ready), .o_tx_valid(tx_valid),
      .o_tx_byte(tx_byte), .i_tx_ready(tx_ready), .o_irq(irq));
   lm_host_model u_lm_host_model (.i_clk(i_clk), .i_rx_ready(rx_ready), .o_rx_valid(rx_valid),
      .o_rx_byte(rx_byte), .i_tx_valid(tx_valid), .i_tx_byte(tx_byte), .o_tx_ready(tx_ready));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      logic aw_done, w_done;
      aw_done = 0;
      w_done = 0;
      awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1;
      while (!(aw_done && w_done))
      begin
         @(posedge i_clk);
         if (awready && !aw_done) begin aw_done = 1; awvalid <= 0; end
         if (wready && !w_done) begin w_done = 1; wvalid <= 0; end
      end
      bready <= 1;
      do @(posedge i_clk); while (!bvalid);
      bready <= 0;
      // Map ends at 0x1C; anything above is refused
      chk({30'h0, bresp}, {30'h0, (a > 8'h1C) ? 2'h2 : 2'h0});
   endtask
   task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      araddr <= a; arvalid <= 1;
      do @(posedge i_clk); while (!arready);
      arvalid <= 0; rready <= 1;
      do @(posedge i_clk); while (!rvalid);
      d = rdata; r = rresp; rready <= 0;
      chk(d, ed);
      chk({30'h0, r}, {30'h0, er});
   endtask
   // Stat byte is fixed at 8'h5A by the main sequence
   task automatic req(input logic [7:0] cmd, input logic [7:0] dat, input logic avail);
      logic [7:0] e [$];
      if (avail) e = '{8'h21, 8'h5A, dat, 8'h21 ^ 8'h5A ^ dat};
      else e = '{8'h21, 8'h5A, 8'h21 ^ 8'h5A, 8'h00, 8'h00};
      u_lm_host_model.got.delete();
      u_lm_host_model.send(cmd, 8'h00, 8'h00);
      for (int i = 0; i < 400 && u_lm_host_model.got.size() < e.size(); i++) @(posedge i_clk);
      repeat (6) @(posedge i_clk);
      chk(u_lm_host_model.got.size(), e.size());
      foreach (e[i]) chk(u_lm_host_model.got[i], e[i]);
   endtask
   task automatic close_out;
      $display("fails=%0d comparisons=%0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   initial
   begin
      #(100 * 20000);
      fails++;
      close_out();
   end
   initial
   begin
      repeat (10) @(posedge i_clk);
      i_rst <= 0;
      @(posedge i_clk);
      axr(`LM_OFS_UNIT, 32'h110, 2'h0);
      axr(`LM_OFS_MODE, 32'h4, 2'h0);
      axr(8'h20, 32'h0, 2'h2);
      axw(8'h20, 32'h1);
      axw(`LM_OFS_SYSSTAT, 32'h5A);
      for (int i = 0; i < 6; i++)
      begin
         axw(`LM_OFS_OPSTATE, i);
         req(8'h84, i[7:0], 1'b1);
      end
      for (int b = 0; b < 5; b++)
      begin
         axw(`LM_OFS_MODE, (b < 4) ? (32'h1 << b) : 32'hF);
         req(8'h14, ((b < 4) ? (8'h1 << b) : 8'h0F) | 8'h04, 1'b1);
      end
      u_lm_host_model.slow = 1'b1;
      axw(`LM_OFS_POWER, 32'h64);
      req(8'h4E, 8'h64, 1'b1);
      u_lm_host_model.slow = 1'b0;
      axw(`LM_OFS_UNIT, 32'h10);
      req(8'h84, 8'h00, 1'b0);
      axw(`LM_OFS_UNIT, 32'h110);
      axw(`LM_OFS_IRQ_MASK, 32'h1);
      repeat (2) @(posedge i_clk);
      chk(irq, 1'b1);
      axr(`LM_OFS_IRQ_STAT, 32'h1, 2'h0);
      repeat (2) @(posedge i_clk);
      chk(irq, 1'b0);
      u_lm_host_model.send(8'h84, 8'h00, 8'h01);
      repeat (6) @(posedge i_clk);
      axr(`LM_OFS_IRQ_STAT, 32'h2, 2'h0);
      u_lm_host_model.send(8'h33, 8'h00, 8'h00);
      repeat (6) @(posedge i_clk);
      chk(tx_valid, 1'b0);
      axr(`LM_OFS_IRQ_STAT, 32'h4, 2'h0);
      close_out();
   end
endmodule
`default_nettype wire
